// ### design/ufc_map.svh
// Purpose: Addresses, field positions, reset values and timing for the function control register.
// Assumes: 6-bit immediate register addresses and a 100 MHz block clock.
// Notes:   Definitions only.
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// Register addresses: write, set and clear.
`define UFC_ADDR_WRITE   6'h04
`define UFC_ADDR_SET     6'h05
`define UFC_ADDR_CLEAR   6'h06

// Field positions.
`define UFC_BIT_RSVD     7
`define UFC_BIT_LPN      6
`define UFC_BIT_RESET    5
`define UFC_OPM_HI       4
`define UFC_OPM_LO       3
`define UFC_BIT_TERM     2
`define UFC_SPD_HI       1
`define UFC_SPD_LO       0

// Reset value: powered, normal mode, full-speed.
`define UFC_RESET_VALUE  8'h41

// Operating mode codes.
`define UFC_OPM_NORMAL   2'h0
`define UFC_OPM_NODRIVE  2'h1
`define UFC_OPM_RAW      2'h2
`define UFC_OPM_NOSYNC   2'h3

// Speed select codes.
`define UFC_SPD_HS       2'h0
`define UFC_SPD_FS       2'h1
`define UFC_SPD_LS       2'h2
`define UFC_SPD_FS4LS    2'h3

// Core reset duration and clock period.
`define UFC_CORE_RESET_NS 200
`define UFC_CLK_PERIOD_NS 10

`endif

// ### design/ufc_pkg.sv
// Purpose: Types shared by the function control register block.
// Assumes: Included map header supplies the numbers.
// Notes:   States are one-hot.
package ufc_pkg;

	// Core reset sequencer states.
	typedef enum logic [2:0] {
		UFC_IDLE  = 3'b001,
		UFC_CORE  = 3'b010,
		UFC_RXCMD = 3'b100
	} ufc_state_t;

	// Whole state of the register block.
	typedef struct packed {
		ufc_state_t state;
		logic [7:0] fc;
		logic       stp_s1;
		logic       stp_s2;
		logic       dir;
		logic       core_reset;
		logic       rxcmd_update;
		logic       low_power;
		logic [7:0] rdata;
		logic       rd_valid;
		logic       tx_drive_en;
		logic       tx_stuff_nrzi_en;
		logic       tx_auto_sync_eop;
		logic       fs_preamble_en;
		logic       hs_term_en;
		logic       fs_pullup_en;
	} ufc_regs_t;

	// Whole state of the delay timer.
	typedef struct packed {
		logic [15:0] count;
		logic        busy;
		logic        done;
	} ufc_timer_t;

endpackage : ufc_pkg

// ### design/ufc_delay_timer.sv
// Purpose: One-shot delay: a start pulse gives a done pulse CYCLES edges later.
// Assumes: Start comes from logic on the same clock.
// Notes:   A start while busy is ignored.
`timescale 1ns/10ps
module ufc_delay_timer
	import ufc_pkg::*;
#(
	parameter int CYCLES = 20
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic arst_n,
	// Control.
	input  wire logic start,
	output logic      done
);

	// Refuse at elaboration a count that the 16-bit down-counter cannot hold.
	if (CYCLES < 1 || CYCLES > 65535) begin : cycles_range_chk
		$error("ufc_delay_timer: CYCLES out of range");
	end

	localparam logic [15:0] LOAD = 16'(CYCLES - 1);

	ufc_timer_t s;
	ufc_timer_t next_s;

	// Count down while busy and pulse done on reaching zero.
	always_comb begin
		next_s      = s;
		next_s.done = 1'b0;
		if (s.busy) begin
			if (s.count == 16'h0000) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.count = s.count - 16'h0001;
			end
		end else if (start) begin
			next_s.busy  = 1'b1;
			next_s.count = LOAD;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;

endmodule : ufc_delay_timer

// ### design/ufc_func_ctrl.sv
// Purpose: Function control register with write, set and clear access and self-clearing bits.
// Assumes: Register port comes from ULPI logic on clk; stp is a pin and is synchronised.
// Notes:   Reads answer only at the three register addresses.
`timescale 1ns/10ps
`include "ufc_map.svh"
module ufc_func_ctrl
	import ufc_pkg::*;
#(
	parameter int CORE_RESET_NS = `UFC_CORE_RESET_NS
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Register port from the ULPI interface logic.
	input  wire logic [5:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rd_valid,
	// Pins and bus-resistor inputs.
	input  wire logic       stp,
	input  wire logic       dplus_low_resistor,
	input  wire logic       dminus_low_resistor,
	// Bus direction and core control.
	output logic            dir,
	output logic            core_reset,
	output logic            rxcmd_update,
	output logic            low_power,
	// Register fields.
	output logic      [1:0] operating_mode,
	output logic            termination_select,
	output logic      [1:0] transceiver_speed_select,
	// Decoded transmit and termination controls.
	output logic            tx_drive_en,
	output logic            tx_stuff_nrzi_en,
	output logic            tx_auto_sync_eop,
	output logic            fs_preamble_en,
	output logic            hs_term_en,
	output logic            fs_pullup_en
);

	// Least time rounds up to whole cycles.
	localparam int CORE_RESET_CYC =
		(CORE_RESET_NS + `UFC_CLK_PERIOD_NS - 1) / `UFC_CLK_PERIOD_NS;

	// Refuse at elaboration a core reset too short to give one cycle of DIR.
	if (CORE_RESET_CYC < 1) begin : reset_len_chk
		$error("ufc_func_ctrl: CORE_RESET_NS too small");
	end

	ufc_regs_t s;
	ufc_regs_t next_s;
	logic      hit;
	logic      timer_start;
	logic      timer_done;

	////////////////////////////////////////////////////////////////////////////////
	// Core reset timer.

	// The timer is started only from idle, so a reset bit held high restarts nothing.
	assign timer_start = (s.state == UFC_IDLE) && s.fc[`UFC_BIT_RESET];

	ufc_delay_timer #(
		.CYCLES (CORE_RESET_CYC)
	) u_core_timer (
		.clk    (clk),
		.arst_n (arst_n),
		.start  (timer_start),
		.done   (timer_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	assign hit = (reg_addr == `UFC_ADDR_WRITE) || (reg_addr == `UFC_ADDR_SET) ||
		(reg_addr == `UFC_ADDR_CLEAR);

	// Bus access first, then hardware updates, so a self-clear or wake-up is never lost.
	always_comb begin
		next_s              = s;
		next_s.stp_s1       = stp;
		next_s.stp_s2       = s.stp_s1;
		next_s.rxcmd_update = 1'b0;
		next_s.rd_valid     = 1'b0;
		// Reads see the value stored before this cycle's write.
		if (reg_rd && hit) begin
			next_s.rd_valid = 1'b1;
			next_s.rdata    = s.fc;
		end
		if (reg_wr) begin
			case (reg_addr)
				`UFC_ADDR_WRITE: begin
					next_s.fc = reg_wdata;
				end
				`UFC_ADDR_SET: begin
					next_s.fc = s.fc | reg_wdata;
				end
				`UFC_ADDR_CLEAR: begin
					next_s.fc = s.fc & ~reg_wdata;
				end
				default: begin
					next_s.fc = s.fc;
				end
			endcase
		end
		// STP while in low power wakes the device and restores the powered bit.
		if (s.low_power && s.stp_s2) begin
			next_s.fc[`UFC_BIT_LPN] = 1'b1;
		end
		// Core reset sequencer.
		case (s.state)
			UFC_IDLE: begin
				if (s.fc[`UFC_BIT_RESET]) begin
					next_s.state      = UFC_CORE;
					next_s.dir        = 1'b1;
					next_s.core_reset = 1'b1;
				end
			end
			UFC_CORE: begin
				if (timer_done) begin
					next_s.state              = UFC_RXCMD;
					next_s.dir                = 1'b0;
					next_s.core_reset         = 1'b0;
					next_s.fc[`UFC_BIT_RESET] = 1'b0;
				end
			end
			UFC_RXCMD: begin
				next_s.state        = UFC_IDLE;
				next_s.rxcmd_update = 1'b1;
			end
			default: begin
				next_s.state      = UFC_IDLE;
				next_s.dir        = 1'b0;
				next_s.core_reset = 1'b0;
			end
		endcase
		// A suspend bit at zero enters low-power mode.
		next_s.low_power = !next_s.fc[`UFC_BIT_LPN];
		// Transmit encoding from the operating mode; preamble enable from the speed select.
		next_s.tx_drive_en      = s.fc[`UFC_OPM_HI:`UFC_OPM_LO] != `UFC_OPM_NODRIVE;
		next_s.tx_stuff_nrzi_en = s.fc[`UFC_OPM_HI:`UFC_OPM_LO] != `UFC_OPM_RAW;
		next_s.tx_auto_sync_eop = s.fc[`UFC_OPM_HI:`UFC_OPM_LO] != `UFC_OPM_NOSYNC;
		next_s.fs_preamble_en   = s.fc[`UFC_SPD_HI:`UFC_SPD_LO] == `UFC_SPD_FS4LS;
		// Terminations: off when not driving; host pull-downs suppress the device pull-up.
		next_s.hs_term_en = !s.fc[`UFC_BIT_TERM] && next_s.tx_drive_en &&
			(s.fc[`UFC_SPD_HI:`UFC_SPD_LO] == `UFC_SPD_HS);
		next_s.fs_pullup_en = s.fc[`UFC_BIT_TERM] && next_s.tx_drive_en &&
			!(dplus_low_resistor && dminus_low_resistor);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// One clock for bus and self-clears, so a read never sees a half update.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s                  <= '0;
			s.state            <= UFC_IDLE;
			s.fc               <= `UFC_RESET_VALUE;
			s.tx_drive_en      <= 1'b1;
			s.tx_stuff_nrzi_en <= 1'b1;
			s.tx_auto_sync_eop <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata                = s.rdata;
	assign reg_rd_valid             = s.rd_valid;
	assign dir                      = s.dir;
	assign core_reset               = s.core_reset;
	assign rxcmd_update             = s.rxcmd_update;
	assign low_power                = s.low_power;
	assign operating_mode           = s.fc[`UFC_OPM_HI:`UFC_OPM_LO];
	assign termination_select       = s.fc[`UFC_BIT_TERM];
	assign transceiver_speed_select = s.fc[`UFC_SPD_HI:`UFC_SPD_LO];
	assign tx_drive_en              = s.tx_drive_en;
	assign tx_stuff_nrzi_en         = s.tx_stuff_nrzi_en;
	assign tx_auto_sync_eop         = s.tx_auto_sync_eop;
	assign fs_preamble_en           = s.fs_preamble_en;
	assign hs_term_en               = s.hs_term_en;
	assign fs_pullup_en             = s.fs_pullup_en;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Plain writes where no self-update can interfere.
	sequence quiet_wr_s(logic [5:0] a);
		reg_wr && reg_addr == a && s.state == UFC_IDLE && !(s.low_power && s.stp_s2);
	endsequence

	sequence reset_done_s;
		$fell(dir) ##0 !s.fc[`UFC_BIT_RESET];
	endsequence

	full_write_a: assert property (quiet_wr_s(`UFC_ADDR_WRITE) |=>
		s.fc[4:0] == $past(reg_wdata[4:0]))
		else $error("full write not stored");
	set_write_a: assert property (quiet_wr_s(`UFC_ADDR_SET) |=>
		s.fc[4:0] == ($past(s.fc[4:0]) | $past(reg_wdata[4:0])))
		else $error("set write wrong");
	clear_write_a: assert property (quiet_wr_s(`UFC_ADDR_CLEAR) |=>
		s.fc[4:0] == ($past(s.fc[4:0]) & ~$past(reg_wdata[4:0])))
		else $error("clear write wrong");
	read_data_a: assert property (reg_rd && hit && !reg_wr |=>
		reg_rd_valid && reg_rdata == $past(s.fc))
		else $error("read data wrong");
	enter_low_power_a: assert property ($fell(s.fc[`UFC_BIT_LPN]) |-> low_power)
		else $error("low power not entered");
	wake_up_a: assert property (low_power && s.stp_s2 |=> !low_power && s.fc[`UFC_BIT_LPN])
		else $error("wake-up did not restore bit");
	core_reset_a: assert property (s.state == UFC_IDLE && s.fc[`UFC_BIT_RESET] |=>
		dir && core_reset)
		else $error("core reset not started");
	reset_finish_a: assert property (reset_done_s |-> ##1 rxcmd_update ##1 !rxcmd_update)
		else $error("no rxcmd after core reset");
	raw_mode_a: assert property (operating_mode == `UFC_OPM_RAW |=> !tx_stuff_nrzi_en)
		else $error("stuffing not disabled");
	preamble_a: assert property (transceiver_speed_select == `UFC_SPD_FS4LS |=> fs_preamble_en)
		else $error("preamble not enabled");

endmodule : ufc_func_ctrl

// ### bench/ufc_link_model.sv
// Purpose: Link-side model that wakes the device and watches bus ownership.
// Assumes: Same clock as the device; wake is a request from the bench.
// Notes:   Stp is registered from low_power, so it stays high one clock after the device wakes.
`timescale 1ns/10ps
module ufc_link_model (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic arst_n,
	// Device status and bench request.
	input  wire logic low_power,
	input  wire logic dir,
	input  wire logic wake,
	// Link outputs.
	output logic      stp,
	output logic      bus_free
);
	// Stp rises only for a sleeping device and drops once it is awake.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) stp <= 1'b0;
		else stp <= wake && low_power;
	end
	// The bench may use the bus only while the device has released it.
	assign bus_free = !dir;
endmodule : ufc_link_model

// ### bench/ufc_func_ctrl_tb.sv
// Purpose: Self-checking bench for the function control register.
// Assumes: Core reset shortened to 10 cycles.
// Notes:   Reads are scored from a queue of expected bytes.
`timescale 1ns/10ps
module ufc_func_ctrl_tb;
	import ufc_pkg::*;
	logic       clk, arst_n, reg_wr, reg_rd, wake, stp, bus_free, reg_rd_valid;
	logic       dplus_low_resistor, dminus_low_resistor, dir, core_reset;
	logic       rxcmd_update, low_power, termination_select, tx_drive_en;
	logic       tx_stuff_nrzi_en, tx_auto_sync_eop, fs_preamble_en, hs_term_en;
	logic       fs_pullup_en;
	logic [1:0] operating_mode, transceiver_speed_select, i;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, shadow;
	logic [7:0] exp_q[$];
	int         num_errors, checked, n;

	ufc_func_ctrl #(.CORE_RESET_NS(100)) dut_u (.clk, .arst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .stp, .dplus_low_resistor,
		.dminus_low_resistor, .dir, .core_reset, .rxcmd_update, .low_power,
		.operating_mode, .termination_select, .transceiver_speed_select, .tx_drive_en,
		.tx_stuff_nrzi_en, .tx_auto_sync_eop, .fs_preamble_en, .hs_term_en, .fs_pullup_en);
	ufc_link_model link_u (.clk, .arst_n, .low_power, .dir, .wake, .stp, .bus_free);

	////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// A used-up wait counts as a mismatch and closes the run.
	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			chk(8'h00, 8'hff);
			print_verdict();
		end
	endtask : tmo

	// One strobe cycle; inputs move 1 ns after the edge.
	task automatic acc(input logic [5:0] a, input logic [7:0] wd, input logic rd);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = wd;
		reg_wr = !rd;
		reg_rd = rd;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : acc

	// Writes keep the bench copy of the register in step.
	task automatic wr(input logic [5:0] a, input logic [7:0] wd);
		shadow = (a == 6'h04) ? wd : (a == 6'h05) ? (shadow | wd) : (shadow & ~wd);
		acc(a, wd, 1'b0);
	endtask : wr

	task automatic rd(input logic [5:0] a);
		exp_q.push_back(shadow);
		acc(a, 8'h00, 1'b1);
	endtask : rd

	// Every read answer takes the oldest expectation; a stray answer is a mismatch.
	always @(negedge clk) begin
		if (reg_rd_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(8'h00, 8'hff);
			else chk(reg_rdata, exp_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{arst_n, reg_wr, reg_rd, wake, dplus_low_resistor, dminus_low_resistor} = '0;
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		shadow = 8'h41;
		n = $urandom(32'h2e93);
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		rd(6'h04);
		$display("reset values done");
		// Random write, set and clear with reads at all three addresses.
		repeat (4) begin
			{dplus_low_resistor, dminus_low_resistor} = 2'($urandom());
			wr(6'h04, (8'($urandom()) & 8'h9f) | 8'h40);
			rd(6'h05);
			chk({3'h0, operating_mode, termination_select, transceiver_speed_select},
				shadow & 8'h1f);
			wr(6'h05, 8'($urandom()) & 8'h9f);
			rd(6'h06);
			acc(6'h07, 8'h00, 1'b1);
			wr(6'h06, 8'($urandom()) & 8'h9f);
			rd(6'h04);
		end
		$display("access kinds done");
		// Each mode with a different speed; no-SYNC mode only at high speed.
		for (int k = 0; k < 4; k++) begin
			i = 2'(k);
			wr(6'h04, {3'b010, i, 1'b0, 2'h3 - i});
			@(posedge clk);
			#1;
			chk({tx_drive_en, tx_stuff_nrzi_en, tx_auto_sync_eop, fs_preamble_en,
				hs_term_en, fs_pullup_en, 2'h0},
				{i != 1, i != 2, i != 3, i == 0, i == 3, 3'h0});
		end
		{dplus_low_resistor, dminus_low_resistor} = 2'b10;
		wr(6'h04, 8'h45);
		@(posedge clk);
		#1;
		chk({7'h0, fs_pullup_en}, 8'h01);
		// Both host pull-downs on: the device pull-up must let go.
		{dplus_low_resistor, dminus_low_resistor} = 2'b11;
		@(posedge clk);
		#1;
		chk({7'h0, fs_pullup_en}, 8'h00);
		$display("modes done");
		// Sleep, then wake by stp; the bit must come back by itself.
		wr(6'h06, 8'h40);
		chk({7'h0, low_power}, 8'h01);
		wake = 1'b1;
		// Outputs are looked at 1 ns after each edge, once they have settled.
		for (n = 0; n < 50 && low_power !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		tmo(n, 50);
		wake = 1'b0;
		shadow = shadow | 8'h40;
		rd(6'h04);
		$display("low power done");
		// Core reset: dir high for the reset, bit clears, then one status update.
		wr(6'h05, 8'h20);
		for (n = 0; n < 10 && dir !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		tmo(n, 10);
		chk({7'h0, core_reset}, 8'h01);
		for (n = 0; n < 200 && bus_free !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		tmo(n, 200);
		chk({7'h0, n >= 9 && n <= 13}, 8'h01);
		@(posedge clk);
		#1;
		chk({7'h0, rxcmd_update}, 8'h01);
		shadow = shadow & 8'hdf;
		rd(6'h04);
		$display("core reset done");
		repeat (3) @(posedge clk);
		chk(8'(exp_q.size()), 8'h00);
		print_verdict();
	end
endmodule : ufc_func_ctrl_tb
